// *** rtl/pfv_top.sv ***
// frame-rate codes and first loop fast-acquire control
`include "pfv_regs.svh"
module pfv_top
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic [7:0] i_rd_addr,
   input wire logic i_auto_detect_enable,
   input wire logic i_det_valid,
   input wire logic [5:0] i_det_format,
   input wire logic i_second_fmt_wr,
   input wire logic [5:0] i_second_output_format_select,
   input wire logic i_third_fmt_wr,
   input wire logic [5:0] i_third_output_format_select,
   input wire logic i_custom_edit,
   input wire logic i_first_loop_locked,
   output logic [7:0] o_rd_data,
   output logic [3:0] o_input_rate_code,
   output logic o_first_output_halve_select,
   output logic o_reference_buffer_type,
   output logic [7:0] o_pump_current_code,
   output logic o_fast_active
);
   // cycles in one half-second unit at the core clock
   localparam int HALF_NS = `PFV_HALF_SEC_NS;
   localparam int CLK_NS = `PFV_CLK_NS;
   localparam logic [22:0] HALF_CYC = 23'(HALF_NS / CLK_NS);

   // all state of the block
   typedef struct packed
   {
      logic [5:0] fmt_in;          // input format
      logic [3:0] code_in;         // input frame code
      logic [3:0] code2;           // second output frame code
      logic [3:0] code3;           // third output frame code
      logic halve;                 // first output halve select
      logic buftype;               // reference buffer type
      logic fasten;                // fast-acquire enable
      logic [3:0] hold;            // hold delay in half seconds
      logic [7:0] fast_cp;         // fast pump current code
      logic [7:0] norm_cp;         // normal pump current code
      pfv_pkg::pfv_acq_e st;       // acquisition state
      logic [22:0] sub_cnt;        // cycles within half second
      logic [3:0] half_cnt;        // elapsed half seconds
      logic [7:0] rd_data;         // read data
      logic [7:0] cp_out;          // current code driven out
      logic fast_out;              // fast active flag out
   } pfv_state_s;

   pfv_state_s s_q;
   pfv_state_s s_d;
   logic [3:0] lut_in;
   logic [3:0] lut2;
   logic [3:0] lut3;
   logic [5:0] in_fmt_src;
   logic wr_fmt;
   logic wr_code_in;
   logic hold_done;

   // source format for the input lookup: detector or host
   assign in_fmt_src = i_auto_detect_enable ? i_det_format : i_wr_data[5:0];
   // host writes to the input format are ignored under auto detect
   assign wr_fmt = i_wr_en && (i_wr_addr == `PFV_ADDR_FMT_IN) && !i_auto_detect_enable;
   assign wr_code_in = wr_fmt || (i_auto_detect_enable && i_det_valid);
   // lock has persisted for the programmed number of half seconds
   assign hold_done = (s_q.half_cnt >= s_q.hold);

   // lookups for input and both outputs
   pfv_code_lut u_lut_in
   (
      .i_format(in_fmt_src),
      .o_code(lut_in)
   );
   pfv_code_lut u_lut2
   (
      .i_format(i_second_output_format_select),
      .o_code(lut2)
   );
   pfv_code_lut u_lut3
   (
      .i_format(i_third_output_format_select),
      .o_code(lut3)
   );

   // next-state logic
   always_comb
   begin
      s_d = s_q;
      // input format and frame code follow detector or host
      if (wr_code_in)
      begin
         s_d.fmt_in = in_fmt_src;
         s_d.code_in = lut_in;
      end
      // output codes refresh on format writes; custom edits win
      if (i_second_fmt_wr)
      begin
         s_d.code2 = lut2;
      end
      if (i_third_fmt_wr)
      begin
         s_d.code3 = lut3;
      end
      if (i_custom_edit)
      begin
         s_d.code2 = `PFV_CUSTOM_CODE;
         s_d.code3 = `PFV_CUSTOM_CODE;
      end
      // host register writes
      if (i_wr_en)
      begin
         case (i_wr_addr)
            `PFV_ADDR_CODE2: s_d.code2 = i_wr_data[3:0];
            `PFV_ADDR_CODE3: s_d.code3 = i_wr_data[3:0];
            `PFV_ADDR_MAIN:
            begin
               s_d.halve = i_wr_data[`PFV_BIT_HALVE];
               s_d.buftype = i_wr_data[`PFV_BIT_BUFTYPE];
               s_d.fasten = i_wr_data[`PFV_BIT_FASTEN];
            end
            `PFV_ADDR_HOLD: s_d.hold = i_wr_data[3:0];
            `PFV_ADDR_FAST_CP: s_d.fast_cp = i_wr_data;
            `PFV_ADDR_NORM_CP: s_d.norm_cp = i_wr_data;
            default: ;
         endcase
      end
      // fast-acquire sequencer
      case (s_q.st)
         pfv_pkg::PFV_ST_IDLE:
         begin
            // counters parked until acquisition starts
            s_d.sub_cnt = '0;
            s_d.half_cnt = '0;
            if (s_q.fasten)
            begin
               s_d.st = pfv_pkg::PFV_ST_FAST;
            end
         end
         pfv_pkg::PFV_ST_FAST:
         begin
            if (!s_q.fasten)
            begin
               s_d.st = pfv_pkg::PFV_ST_NORM;
            end
            // lock dropped: the hold timer starts over
            else if (!i_first_loop_locked)
            begin
               s_d.sub_cnt = '0;
               s_d.half_cnt = '0;
            end
            // lock held long enough: drop to normal current
            else if (hold_done)
            begin
               s_d.st = pfv_pkg::PFV_ST_NORM;
            end
            // half-second boundary reached
            else if (s_q.sub_cnt == HALF_CYC - 23'd1)
            begin
               s_d.sub_cnt = '0;
               s_d.half_cnt = s_q.half_cnt + 4'd1;
            end
            else
            begin
               s_d.sub_cnt = s_q.sub_cnt + 23'd1;
            end
         end
         pfv_pkg::PFV_ST_NORM:
         begin
            s_d.sub_cnt = '0;
            s_d.half_cnt = '0;
            // losing lock re-enters acquisition with fast current
            if (s_q.fasten && !i_first_loop_locked)
            begin
               s_d.st = pfv_pkg::PFV_ST_FAST;
            end
         end
         // illegal state codes fall back to idle
         default: s_d.st = pfv_pkg::PFV_ST_IDLE;
      endcase
      // current code and fast flag outputs
      s_d.fast_out = (s_d.st == pfv_pkg::PFV_ST_FAST);
      s_d.cp_out = s_d.fast_out ? s_d.fast_cp : s_d.norm_cp;
      // read mux
      case (i_rd_addr)
         `PFV_ADDR_FMT_IN: s_d.rd_data = {s_q.fmt_in[3:0], s_q.code_in};
         `PFV_ADDR_CODE2: s_d.rd_data = {4'h0, s_q.code2};
         `PFV_ADDR_CODE3: s_d.rd_data = {4'h0, s_q.code3};
         `PFV_ADDR_MAIN: s_d.rd_data = {3'h0, s_q.halve, 1'b0, s_q.buftype, 1'b0, s_q.fasten};
         `PFV_ADDR_HOLD: s_d.rd_data = {4'h0, s_q.hold};
         `PFV_ADDR_FAST_CP: s_d.rd_data = s_q.fast_cp;
         `PFV_ADDR_NORM_CP: s_d.rd_data = s_q.norm_cp;
         default: s_d.rd_data = 8'h00;
      endcase
   end

   // state register with synchronous reset
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         // every field to its reset value
         s_q <= '0;
         s_q.code_in <= `PFV_RST_CODE_IN;
         s_q.code2 <= `PFV_RST_CODE2;
         s_q.code3 <= `PFV_RST_CODE3;
         s_q.fasten <= `PFV_RST_FASTEN;
         s_q.hold <= `PFV_RST_HOLD;
         s_q.fast_cp <= `PFV_RST_FAST_CP;
         s_q.norm_cp <= `PFV_RST_NORM_CP;
         s_q.st <= pfv_pkg::PFV_ST_IDLE;
         s_q.cp_out <= `PFV_RST_NORM_CP;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs straight from flip-flops
   assign o_rd_data = s_q.rd_data;
   assign o_input_rate_code = s_q.code_in;
   assign o_first_output_halve_select = s_q.halve;
   assign o_reference_buffer_type = s_q.buftype;
   assign o_pump_current_code = s_q.cp_out;
   assign o_fast_active = s_q.fast_out;

   // rule checks on the registered state, all in the core clock domain
   // fast current never chosen while enable is clear
   fast_gate_a: assert property (@(posedge i_clock) disable iff (i_rst)
      !s_q.fasten |=> !o_fast_active)
      else $error("fast current used while disabled");
   // enabled idle state always enters fast acquisition
   fast_enter_a: assert property (@(posedge i_clock) disable iff (i_rst)
      s_q.st == pfv_pkg::PFV_ST_IDLE && s_q.fasten |=> o_fast_active)
      else $error("fast acquisition not started");
   // lock loss in fast state clears the half-second count
   lock_restart_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (s_q.st == pfv_pkg::PFV_ST_FAST && s_q.fasten && !i_first_loop_locked)
      |=> s_q.half_cnt == 4'd0 && s_q.sub_cnt == 23'd0)
      else $error("hold timer not restarted");
   // leaving fast state for normal needs lock held long enough
   hold_exit_a: assert property (@(posedge i_clock) disable iff (i_rst)
      ($past(s_q.st) == pfv_pkg::PFV_ST_FAST && s_q.st == pfv_pkg::PFV_ST_NORM
      && $past(s_q.fasten)) |-> $past(s_q.half_cnt) >= $past(s_q.hold))
      else $error("left fast acquisition early");
   // pump code follows fast flag
   pump_select_a: assert property (@(posedge i_clock) disable iff (i_rst)
      o_pump_current_code == (o_fast_active ? s_q.fast_cp : s_q.norm_cp))
      else $error("wrong pump current code");
   // normal state always drives the normal pump code
   norm_code_a: assert property (@(posedge i_clock) disable iff (i_rst)
      s_q.st == pfv_pkg::PFV_ST_NORM |-> o_pump_current_code == s_q.norm_cp)
      else $error("normal state with wrong pump code");
   // custom edit forces both output codes to custom
   custom_code_a: assert property (@(posedge i_clock) disable iff (i_rst)
      i_custom_edit && !i_wr_en
      |=> s_q.code2 == `PFV_CUSTOM_CODE && s_q.code3 == `PFV_CUSTOM_CODE)
      else $error("custom code not set");
   // input code holds under auto detect with no detection
   auto_ro_a: assert property (@(posedge i_clock) disable iff (i_rst)
      i_auto_detect_enable && !i_det_valid |=> $stable(s_q.code_in))
      else $error("input code changed under auto detect");
   // input format holds under auto detect with no detection
   fmt_refuse_a: assert property (@(posedge i_clock) disable iff (i_rst)
      i_auto_detect_enable && !i_det_valid |=> $stable(s_q.fmt_in))
      else $error("input format changed under auto detect");
   // second format write loads its lookup code
   second_lut_a: assert property (@(posedge i_clock) disable iff (i_rst)
      i_second_fmt_wr && !i_custom_edit && !i_wr_en |=> s_q.code2 == $past(lut2))
      else $error("second code not refreshed");
   // third format write loads its lookup code
   third_lut_a: assert property (@(posedge i_clock) disable iff (i_rst)
      i_third_fmt_wr && !i_custom_edit && !i_wr_en |=> s_q.code3 == $past(lut3))
      else $error("third code not refreshed");
   // halve bit follows a control register write
   halve_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
      i_wr_en && i_wr_addr == `PFV_ADDR_MAIN
      |=> o_first_output_halve_select == $past(i_wr_data[`PFV_BIT_HALVE]))
      else $error("halve select not written");
   // buffer type bit follows a control register write
   buffer_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
      i_wr_en && i_wr_addr == `PFV_ADDR_MAIN
      |=> o_reference_buffer_type == $past(i_wr_data[`PFV_BIT_BUFTYPE]))
      else $error("buffer type not written");
   // half-second tick spacing
   half_tick_a: assert property (@(posedge i_clock) disable iff (i_rst)
      s_q.half_cnt != $past(s_q.half_cnt) && s_q.half_cnt != 4'd0
      |-> $past(s_q.sub_cnt) == HALF_CYC - 23'd1)
      else $error("half-second tick misplaced");
endmodule // pfv_top

// *** rtl/pfv_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef PFV_REGS_SVH
`define PFV_REGS_SVH
`define PFV_ADDR_FMT_IN 8'h21
`define PFV_ADDR_CODE2 8'h22
`define PFV_ADDR_CODE3 8'h23
`define PFV_ADDR_MAIN 8'h25
`define PFV_ADDR_HOLD 8'h26
`define PFV_ADDR_FAST_CP 8'h27
`define PFV_ADDR_NORM_CP 8'h28
`define PFV_RST_CODE_IN 4'h3
`define PFV_RST_CODE2 4'h5
`define PFV_RST_CODE3 4'h6
`define PFV_RST_FAST_CP 8'h1f
`define PFV_RST_NORM_CP 8'h08
`define PFV_RST_HOLD 4'h0
`define PFV_RST_FASTEN 1'b1
`define PFV_CUSTOM_CODE 4'he
`define PFV_BIT_HALVE 4
`define PFV_BIT_BUFTYPE 2
`define PFV_BIT_FASTEN 0
`define PFV_HALF_SEC_NS 500000000
`define PFV_CLK_NS 100
`define PFV_HALF_SEC_CYC 23'd5000000
`endif

// *** rtl/pfv_pkg.sv ***
// shared types for the frame code and fast-acquire block
package pfv_pkg;
   typedef enum logic [2:0]
   {
      PFV_ST_IDLE = 3'b001,
      PFV_ST_FAST = 3'b010,
      PFV_ST_NORM = 3'b100
   } pfv_acq_e;
endpackage

// *** rtl/pfv_code_lut.sv ***
// format-to-frame-code lookup shared by the input and output paths
module pfv_code_lut
(
   input wire logic [5:0] i_format,
   output logic [3:0] o_code
);
   // the full six-bit format selects a code; formats above 7 report custom
   always_comb
   begin
      case (i_format)
         6'h00: o_code = 4'h1;
         6'h01: o_code = 4'h2;
         6'h02: o_code = 4'h3;
         6'h03: o_code = 4'h4;
         6'h04: o_code = 4'h5;
         6'h05: o_code = 4'h6;
         6'h06: o_code = 4'h7;
         6'h07: o_code = 4'h8;
         default: o_code = `PFV_CUSTOM_CODE;
      endcase
   end
endmodule // pfv_code_lut

// *** verification/pfv_host_model.sv ***
// host-side model that issues one-cycle register write strobes
module pfv_host_model
(
   input wire logic i_clock,
   input wire logic i_go,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_data,
   output logic o_wr_en = 1'b0,
   output logic [7:0] o_wr_addr = 8'h00,
   output logic [7:0] o_wr_data = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   // at most one strobe per request; idle data lines toggle, never hold
   always @(posedge i_clock)
   begin
      // reserved delay values never leave the host
      o_wr_en <= i_go && !(i_addr == 8'h26 && i_data[3:0] > 4'ha);
      if (i_go)
      begin
         o_wr_addr <= i_addr;
         o_wr_data <= i_data;
      end
      else
         o_wr_data <= ~o_wr_data;
   end
endmodule // pfv_host_model

// *** verification/pll1_fastlock_and_vsync_codes_test.sv ***
// self-checking bench for frame codes and fast-acquire control
module pll1_fastlock_and_vsync_codes_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, go = 1'b0, auto_en = 1'b0, det_valid = 1'b0;
   logic fmt2_wr = 1'b0, fmt3_wr = 1'b0, custom = 1'b0, locked = 1'b0;
   logic [7:0] h_addr = 8'h00, h_data = 8'h00, rd_addr = 8'h00;
   logic [5:0] det_fmt = 6'h00, fmt2 = 6'h00, fmt3 = 6'h00;
   logic wr_en, halve, buf_type, fast;
   logic [7:0] wr_addr, wr_data, rd_data, pump, seen, fcp, ncp;
   logic [3:0] rate_code;
   logic [9:0] notes[$]; // {kind, expected}
   logic [9:0] note;
   logic [31:0] seed = 32'h7127;
   int fails = 0, total_checks = 0;
   pfv_host_model host (.i_clock(clk), .i_go(go), .i_addr(h_addr), .i_data(h_data),
      .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
   pfv_top dut (.i_clock(clk), .i_rst(rst), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
      .i_wr_data(wr_data), .i_rd_addr(rd_addr), .i_auto_detect_enable(auto_en),
      .i_det_valid(det_valid), .i_det_format(det_fmt), .i_second_fmt_wr(fmt2_wr),
      .i_second_output_format_select(fmt2), .i_third_fmt_wr(fmt3_wr),
      .i_third_output_format_select(fmt3), .i_custom_edit(custom),
      .i_first_loop_locked(locked), .o_rd_data(rd_data), .o_input_rate_code(rate_code),
      .o_first_output_halve_select(halve), .o_reference_buffer_type(buf_type),
      .o_pump_current_code(pump), .o_fast_active(fast));
   // free-running 10 MHz clock
   initial forever #50 clk = ~clk;
   // pseudo-random source
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // wait a number of rising edges
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // note an expectation: 0 read data, 1 rate code, 2 pump, 3 status bits
   task automatic chk(input logic [1:0] k, input logic [7:0] e);
      notes.push_back({k, e});
      tick(1);
   endtask
   // one register write through the host model
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      go <= 1'b1;
      h_addr <= a;
      h_data <= d;
      tick(1);
      go <= 1'b0;
      tick(3);
   endtask
   // one register read, data one cycle after the address is taken
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_addr <= a;
      tick(2);
      chk(2'd0, e);
   endtask
   // verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // compares every pending note against settled outputs
   always @(negedge clk)
   begin
      while (notes.size() > 0)
      begin
         note = notes.pop_front();
         case (note[9:8])
            2'd0: seen = rd_data;
            2'd1: seen = {4'h0, rate_code};
            2'd2: seen = pump;
            default: seen = {5'h00, halve, buf_type, fast};
         endcase
         total_checks++;
         if (seen !== note[7:0])
         begin
            fails++;
            $display("[ERR] %0t kind %0d got %h want %h", $time, note[9:8], seen, note[7:0]);
         end
      end
   end
   // hang guard, far beyond the 150 or so cycles of the tests
   initial
   begin
      tick(5000);
      fails++;
      tally_and_finish();
   end
   // main sequence
   initial
   begin
      tick(5);
      rst <= 1'b0;
      tick(3);
      rd(8'h22, 8'h05);
      rd(8'h23, 8'h06);
      rd(8'h26, 8'h00);
      rd(8'h27, 8'h1f);
      rd(8'h28, 8'h08);
      rd(8'h30, 8'h00);
      chk(2'd1, 8'h03);
      chk(2'd2, 8'h1f);
      chk(2'd3, 8'h01);
      $display("reset values done");
      seed = lfsr(seed);
      fcp = seed[7:0];
      wr(8'h27, fcp);
      seed = lfsr(seed);
      ncp = seed[7:0];
      wr(8'h28, ncp);
      chk(2'd2, fcp);
      locked <= 1'b1;
      tick(4);
      chk(2'd2, ncp);
      chk(2'd3, 8'h00);
      locked <= 1'b0;
      tick(3);
      chk(2'd2, fcp);
      chk(2'd3, 8'h01);
      $display("fast acquire done");
      wr(8'h25, 8'h14);
      chk(2'd3, 8'h06);
      chk(2'd2, ncp);
      wr(8'h25, 8'h01);
      chk(2'd3, 8'h01);
      wr(8'h26, 8'h0a);
      rd(8'h26, 8'h0a);
      wr(8'h26, 8'h0c);
      rd(8'h26, 8'h0a);
      locked <= 1'b1;
      tick(20);
      chk(2'd3, 8'h01);
      locked <= 1'b0;
      $display("control bits done");
      wr(8'h21, 8'h05);
      rd(8'h21, 8'h56);
      chk(2'd1, 8'h06);
      fmt2 <= 6'd2;
      fmt2_wr <= 1'b1;
      fmt3 <= 6'd7;
      fmt3_wr <= 1'b1;
      tick(1);
      fmt2_wr <= 1'b0;
      fmt3_wr <= 1'b0;
      tick(2);
      rd(8'h22, 8'h03);
      rd(8'h23, 8'h08);
      custom <= 1'b1;
      tick(1);
      custom <= 1'b0;
      tick(2);
      rd(8'h22, 8'h0e);
      rd(8'h23, 8'h0e);
      $display("format codes done");
      auto_en <= 1'b1;
      tick(1);
      wr(8'h21, 8'h01);
      chk(2'd1, 8'h06);
      det_fmt <= 6'h03;
      det_valid <= 1'b1;
      tick(1);
      det_valid <= 1'b0;
      tick(2);
      chk(2'd1, 8'h04);
      rd(8'h21, 8'h34);
      $display("auto detect done");
      auto_en <= 1'b0;
      wr(8'h25, 8'h14);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(2);
      chk(2'd3, 8'h01);
      chk(2'd2, 8'h1f);
      rd(8'h22, 8'h05);
      rd(8'h21, 8'h03);
      $display("second reset done");
      tally_and_finish();
   end
endmodule // pll1_fastlock_and_vsync_codes_test
